// ---- rtl/acq_pkg.sv ----
package acq_pkg;

  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_PRE     = 4'h2;
  localparam logic [3:0] REG_POST    = 4'h3;
  localparam logic [3:0] REG_RECS    = 4'h4;
  localparam logic [3:0] REG_LEVEL   = 4'h5;
  localparam logic [3:0] REG_DONE    = 4'h6;
  localparam logic [3:0] REG_TS_LO   = 4'h7;
  localparam logic [3:0] REG_TS_HI   = 4'h8;
  localparam logic [3:0] REG_RD_ADDR = 4'h9;
  localparam logic [3:0] REG_RD_DATA = 4'ha;

  localparam int CTRL_START     = 0;
  localparam int CTRL_ABORT     = 1;
  localparam int CTRL_TS_CLR    = 2;
  localparam int CTRL_DUAL      = 3;
  localparam int CTRL_TS_FIXED  = 4;
  localparam int CTRL_CLR_START = 5;
  localparam int CTRL_SLOPE_NEG = 6;
  localparam int CTRL_SRC_B     = 7;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_ARMED = 1;
  localparam int STAT_DONE  = 2;
  localparam int STAT_OVF   = 3;

  localparam logic [15:0] PRE_RST   = 16'h0010;
  localparam logic [15:0] POST_RST  = 16'h0030;
  localparam logic [31:0] RECS_RST  = 32'h0000_0001;
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [7:0]  CTRL_RST  = 8'h00;

  localparam int TS_W       = 44;
  localparam int SAMPLE_W   = 16;
  localparam int FOOT_WORDS = 4;
  localparam int RD_LAT     = 1;

  localparam int CLK_PERIOD_NS = 10;
  localparam int REARM_MAX_NS  = 1000;
  localparam int REARM_MAX_CYC = REARM_MAX_NS / CLK_PERIOD_NS;
  localparam int FIXED_CLK_NS  = 100;
  localparam int FIXED_DIV     = FIXED_CLK_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_ARMED = 4'b0010,
    S_POST  = 4'b0100,
    S_FOOT  = 4'b1000
  } state_e;

endpackage

// ---- rtl/ts_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
module ts_counter #(
  parameter int W   = acq_pkg::TS_W,
  parameter int DIV = acq_pkg::FIXED_DIV
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         samp_tick,
  input  wire logic         sel_fixed,
  output logic      [W-1:0] count
);

  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic [W-1:0] next_count;
  logic        tick;

  always_comb begin
    next_div_cnt = (div_cnt == 16'(DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    tick = sel_fixed ? (div_cnt == 16'(DIV - 1)) : samp_tick;
    next_count = count;
    if (clr) begin
      next_count = '0;
    end else if (tick) begin
      next_count = count + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      count   <= '0;
    end else if (ce) begin
      div_cnt <= next_div_cnt;
      count   <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);

  tick_count_a: assert property (tick && !clr && count != '1 |=> count == $past(count) + W'(1))
    else $error("timestamp did not advance on tick");
  wrap_zero_a: assert property (tick && !clr && count == '1 |=> count == '0)
    else $error("timestamp did not wrap to zero");
  clear_cmd_a: assert property (clr |=> count == '0)
    else $error("timestamp not cleared");
  fixed_sel_a: assert property (sel_fixed && !clr && div_cnt != 16'(DIV - 1) |=> count == $past(count))
    else $error("fixed clock select counted off-tick");
  wrap_c: cover property (tick && count == '1);

endmodule
`default_nettype wire

// ---- rtl/trig_detect.sv ----
`timescale 1ns/100ps
`default_nettype none
module trig_detect #(
  parameter int W = acq_pkg::SAMPLE_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         valid,
  input  wire logic [W-1:0] sample,
  input  wire logic [W-1:0] level,
  input  wire logic         slope_neg,
  output logic              trig
);

  logic [W-1:0] prev;
  logic         have_prev;
  logic [W-1:0] next_prev;
  logic         next_have_prev;
  logic         up;
  logic         down;

  always_comb begin
    up   = ($signed(prev) < $signed(level)) && ($signed(sample) >= $signed(level));
    down = ($signed(prev) > $signed(level)) && ($signed(sample) <= $signed(level));
    trig = valid && have_prev && (slope_neg ? down : up);
    next_prev      = valid ? sample : prev;
    next_have_prev = have_prev || valid;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev      <= '0;
      have_prev <= 1'b0;
    end else if (ce) begin
      prev      <= next_prev;
      have_prev <= next_have_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);

  cross_dir_a: assert property (trig |-> (slope_neg ? $signed(sample) <= $signed(level)
                                                    : $signed(sample) >= $signed(level)))
    else $error("trigger without level crossing");

endmodule
`default_nettype wire

// ---- rtl/acq_seq.sv ----
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module acq_seq #(
  parameter int AW = 32
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        SAMPLE_VALID,
  input  wire logic [15:0] SAMPLE_A,
  input  wire logic [15:0] SAMPLE_B,
  output logic             MEM_A_WE,
  output logic    [AW-1:0] MEM_A_ADDR,
  output logic      [15:0] MEM_A_DATA,
  output logic             MEM_B_WE,
  output logic    [AW-1:0] MEM_B_ADDR,
  output logic      [15:0] MEM_B_DATA,
  output logic             MEM_RD_EN,
  output logic    [AW-1:0] MEM_RD_ADDR,
  input  wire logic [15:0] MEM_RD_DATA
);

  localparam int REARM_BOUND = acq_pkg::REARM_MAX_CYC;
  localparam logic [AW-1:0] HALF = {1'b1, {(AW-1){1'b0}}};

  // Configuration and bus state
  logic [7:0]    ctrl;
  logic [15:0]   pre_cnt;
  logic [15:0]   post_cnt;
  logic [31:0]   rec_cnt;
  logic [15:0]   level;
  logic [AW-1:0] rd_addr;
  logic          av_wait;
  logic [31:0]   av_rdata;
  logic          rd_en;
  logic          rd_busy;
  logic [3:0]    rd_cnt;
  logic [7:0]    next_ctrl;
  logic [15:0]   next_pre_cnt;
  logic [15:0]   next_post_cnt;
  logic [31:0]   next_rec_cnt;
  logic [15:0]   next_level;
  logic [AW-1:0] next_rd_addr;
  logic          next_av_wait;
  logic [31:0]   next_av_rdata;
  logic          next_rd_en;
  logic          next_rd_busy;
  logic [3:0]    next_rd_cnt;

  // Sequencer state
  acq_pkg::state_e state;
  acq_pkg::state_e next_state;
  logic [AW-1:0] rb;
  logic [15:0]   pre_ptr;
  logic [15:0]   post_idx;
  logic [1:0]    foot_idx;
  logic [43:0]   ts_hold;
  logic [15:0]   ring_hold;
  logic [31:0]   recs_done;
  logic          done;
  logic          ovf;
  logic          mem_we;
  logic [AW-1:0] mem_off;
  logic [15:0]   mem_da;
  logic [15:0]   mem_db;
  logic [AW-1:0] next_rb;
  logic [15:0]   next_pre_ptr;
  logic [15:0]   next_post_idx;
  logic [1:0]    next_foot_idx;
  logic [43:0]   next_ts_hold;
  logic [15:0]   next_ring_hold;
  logic [31:0]   next_recs_done;
  logic          next_done;
  logic          next_ovf;
  logic          wr;
  logic [AW-1:0] off;
  logic [15:0]   da;
  logic [15:0]   db;

  logic          take;
  logic          busy;
  logic          start;
  logic          abort;
  logic          ts_clr;
  logic          trig;
  logic [43:0]   ts_now;
  logic [15:0]   post_eff;
  logic [AW:0]   stride;
  logic [AW:0]   limit;
  logic          seq_last;
  logic [15:0]   foot_word;

  ////////////////////////////////////////////////////////////////////////////
  // Timestamp counter and level trigger

  ts_counter #(
    .W   (acq_pkg::TS_W),
    .DIV (acq_pkg::FIXED_DIV)
  ) u_ts (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .ce        (CE),
    .clr       (ts_clr),
    .samp_tick (SAMPLE_VALID),
    .sel_fixed (ctrl[acq_pkg::CTRL_TS_FIXED]),
    .count     (ts_now)
  );

  trig_detect #(
    .W (acq_pkg::SAMPLE_W)
  ) u_trig (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .ce        (CE),
    .valid     (SAMPLE_VALID),
    .sample    (ctrl[acq_pkg::CTRL_SRC_B] ? SAMPLE_B : SAMPLE_A),
    .level     (level),
    .slope_neg (ctrl[acq_pkg::CTRL_SLOPE_NEG]),
    .trig      (trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared decode

  always_comb begin
    busy     = (state != acq_pkg::S_IDLE);
    take     = (AVS_READ || AVS_WRITE) && av_wait && !rd_busy;
    start    = take && AVS_WRITE && AVS_ADDRESS == acq_pkg::REG_CTRL && AVS_WRITEDATA[acq_pkg::CTRL_START];
    abort    = take && AVS_WRITE && AVS_ADDRESS == acq_pkg::REG_CTRL && AVS_WRITEDATA[acq_pkg::CTRL_ABORT];
    ts_clr   = (take && AVS_WRITE && AVS_ADDRESS == acq_pkg::REG_CTRL && AVS_WRITEDATA[acq_pkg::CTRL_TS_CLR])
             || (start && !busy && AVS_WRITEDATA[acq_pkg::CTRL_CLR_START]);
    post_eff = (post_cnt == 16'h0000) ? 16'h0001 : post_cnt;
    stride   = (AW+1)'(pre_cnt) + (AW+1)'(post_eff) + (AW+1)'(acq_pkg::FOOT_WORDS);
    limit    = ctrl[acq_pkg::CTRL_DUAL] ? {1'b0, HALF} : {1'b1, {AW{1'b0}}};
    seq_last = (recs_done + 32'h1) >= rec_cnt;
    unique case (foot_idx)
      2'd0: foot_word = ts_hold[15:0];
      2'd1: foot_word = ts_hold[31:16];
      2'd2: foot_word = {4'h0, ts_hold[43:32]};
      2'd3: foot_word = ring_hold;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave, configuration and memory readback

  always_comb begin
    next_ctrl     = ctrl;
    next_pre_cnt  = pre_cnt;
    next_post_cnt = post_cnt;
    next_rec_cnt  = rec_cnt;
    next_level    = level;
    next_rd_addr  = rd_addr;
    next_av_wait  = 1'b1;
    next_av_rdata = av_rdata;
    next_rd_en    = 1'b0;
    next_rd_busy  = rd_busy;
    next_rd_cnt   = rd_cnt;
    if (rd_busy) begin
      next_rd_cnt = rd_cnt - 4'h1;
      if (rd_cnt == 4'h0) begin
        next_av_rdata = {16'h0000, MEM_RD_DATA};
        next_av_wait  = 1'b0;
        next_rd_busy  = 1'b0;
        next_rd_cnt   = 4'h0;
        next_rd_addr  = rd_addr + AW'(1);
      end
    end else if (take && AVS_WRITE) begin
      next_av_wait = 1'b0;
      if (!busy) begin
        unique case (AVS_ADDRESS)
          acq_pkg::REG_CTRL:    next_ctrl     = {AVS_WRITEDATA[7:3], 3'b000};
          acq_pkg::REG_PRE:     next_pre_cnt  = AVS_WRITEDATA[15:0];
          acq_pkg::REG_POST:    next_post_cnt = AVS_WRITEDATA[15:0];
          acq_pkg::REG_RECS:    next_rec_cnt  = AVS_WRITEDATA;
          acq_pkg::REG_LEVEL:   next_level    = AVS_WRITEDATA[15:0];
          acq_pkg::REG_RD_ADDR: next_rd_addr  = AW'(AVS_WRITEDATA);
          default:              next_ctrl     = ctrl;
        endcase
      end
    end else if (take && AVS_READ && AVS_ADDRESS == acq_pkg::REG_RD_DATA && !busy) begin
      next_rd_en   = 1'b1;
      next_rd_busy = 1'b1;
      next_rd_cnt  = 4'(acq_pkg::RD_LAT);
    end else if (take && AVS_READ) begin
      next_av_wait = 1'b0;
      unique case (AVS_ADDRESS)
        acq_pkg::REG_CTRL:    next_av_rdata = {24'h0, ctrl};
        acq_pkg::REG_STATUS:  next_av_rdata = {28'h0, ovf, done, state == acq_pkg::S_ARMED, busy};
        acq_pkg::REG_PRE:     next_av_rdata = {16'h0, pre_cnt};
        acq_pkg::REG_POST:    next_av_rdata = {16'h0, post_cnt};
        acq_pkg::REG_RECS:    next_av_rdata = rec_cnt;
        acq_pkg::REG_LEVEL:   next_av_rdata = {16'h0, level};
        acq_pkg::REG_DONE:    next_av_rdata = recs_done;
        acq_pkg::REG_TS_LO:   next_av_rdata = ts_now[31:0];
        acq_pkg::REG_TS_HI:   next_av_rdata = {20'h0, ts_now[43:32]};
        acq_pkg::REG_RD_ADDR: next_av_rdata = 32'(rd_addr);
        default:              next_av_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ctrl            <= acq_pkg::CTRL_RST;
      pre_cnt         <= acq_pkg::PRE_RST;
      post_cnt        <= acq_pkg::POST_RST;
      rec_cnt         <= acq_pkg::RECS_RST;
      level           <= acq_pkg::LEVEL_RST;
      rd_addr         <= '0;
      av_wait         <= 1'b1;
      av_rdata        <= 32'h0000_0000;
      rd_en           <= 1'b0;
      rd_busy         <= 1'b0;
      rd_cnt          <= 4'h0;
    end else if (CE) begin
      ctrl            <= next_ctrl;
      pre_cnt         <= next_pre_cnt;
      post_cnt        <= next_post_cnt;
      rec_cnt         <= next_rec_cnt;
      level           <= next_level;
      rd_addr         <= next_rd_addr;
      av_wait         <= next_av_wait;
      av_rdata        <= next_av_rdata;
      rd_en           <= next_rd_en;
      rd_busy         <= next_rd_busy;
      rd_cnt          <= next_rd_cnt;
    end
  end

  assign AVS_WAITREQUEST = av_wait;
  assign AVS_READDATA    = av_rdata;
  assign MEM_RD_EN       = rd_en;
  assign MEM_RD_ADDR     = rd_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Record sequencer

  always_comb begin
    next_state     = state;
    next_rb        = rb;
    next_pre_ptr   = pre_ptr;
    next_post_idx  = post_idx;
    next_foot_idx  = foot_idx;
    next_ts_hold   = ts_hold;
    next_ring_hold = ring_hold;
    next_recs_done = recs_done;
    next_done      = done;
    next_ovf       = ovf;
    wr             = 1'b0;
    off            = '0;
    da             = SAMPLE_A;
    db             = SAMPLE_B;
    unique case (state)
      acq_pkg::S_IDLE: begin
        if (start) begin
          next_rb        = '0;
          next_recs_done = 32'h0;
          next_pre_ptr   = 16'h0000;
          next_done      = 1'b0;
          next_ovf       = stride > limit;
          next_done      = stride > limit;
          if (stride <= limit) begin
            next_state = acq_pkg::S_ARMED;
          end
        end
      end
      acq_pkg::S_ARMED: begin
        if (SAMPLE_VALID && trig) begin
          next_ts_hold   = ts_now;
          next_ring_hold = pre_ptr;
          wr             = 1'b1;
          off            = rb + AW'(pre_cnt);
          next_post_idx  = 16'h0001;
          next_foot_idx  = 2'd0;
          next_state     = (post_eff == 16'h0001) ? acq_pkg::S_FOOT : acq_pkg::S_POST;
        end else if (SAMPLE_VALID && pre_cnt != 16'h0000) begin
          wr           = 1'b1;
          off          = rb + AW'(pre_ptr);
          next_pre_ptr = (pre_ptr == pre_cnt - 16'h0001) ? 16'h0000 : pre_ptr + 16'h0001;
        end
      end
      acq_pkg::S_POST: begin
        if (SAMPLE_VALID) begin
          wr            = 1'b1;
          off           = rb + AW'(pre_cnt) + AW'(post_idx);
          next_post_idx = post_idx + 16'h0001;
          if (post_idx + 16'h0001 >= post_eff) begin
            next_state = acq_pkg::S_FOOT;
          end
        end
      end
      acq_pkg::S_FOOT: begin
        wr            = 1'b1;
        off           = rb + AW'(pre_cnt) + AW'(post_eff) + AW'(foot_idx);
        da            = foot_word;
        db            = foot_word;
        next_foot_idx = foot_idx + 2'd1;
        if (foot_idx == 2'd3) begin
          next_recs_done = recs_done + 32'h1;
          next_pre_ptr   = 16'h0000;
          next_rb        = rb + stride[AW-1:0];
          if (seq_last) begin
            next_state = acq_pkg::S_IDLE;
            next_done  = 1'b1;
          end else if ({1'b0, rb} + stride + stride > limit) begin
            next_state = acq_pkg::S_IDLE;
            next_done  = 1'b1;
            next_ovf   = 1'b1;
          end else begin
            next_state = acq_pkg::S_ARMED;
          end
        end
      end
      default: next_state = acq_pkg::S_IDLE;
    endcase
    if (abort && busy) begin
      next_state = acq_pkg::S_IDLE;
      next_done  = 1'b1;
      wr         = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state     <= acq_pkg::S_IDLE;
      rb        <= '0;
      pre_ptr   <= 16'h0000;
      post_idx  <= 16'h0000;
      foot_idx  <= 2'd0;
      ts_hold   <= 44'h0;
      ring_hold <= 16'h0000;
      recs_done <= 32'h0;
      done      <= 1'b0;
      ovf       <= 1'b0;
      mem_we    <= 1'b0;
      mem_off   <= '0;
      mem_da    <= 16'h0000;
      mem_db    <= 16'h0000;
    end else if (CE) begin
      state     <= next_state;
      rb        <= next_rb;
      pre_ptr   <= next_pre_ptr;
      post_idx  <= next_post_idx;
      foot_idx  <= next_foot_idx;
      ts_hold   <= next_ts_hold;
      ring_hold <= next_ring_hold;
      recs_done <= next_recs_done;
      done      <= next_done;
      ovf       <= next_ovf;
      mem_we    <= wr;
      mem_off   <= off;
      mem_da    <= da;
      mem_db    <= db;
    end
  end

  // Channel B lands in the upper half when both channels run
  logic          dual_we;
  logic [AW-1:0] mem_b_off;
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dual_we   <= 1'b0;
      mem_b_off <= '0;
    end else if (CE) begin
      dual_we   <= wr && ctrl[acq_pkg::CTRL_DUAL];
      mem_b_off <= off + HALF;
    end
  end

  assign MEM_A_WE   = mem_we;
  assign MEM_A_ADDR = mem_off;
  assign MEM_A_DATA = mem_da;
  assign MEM_B_WE   = dual_we;
  assign MEM_B_ADDR = mem_b_off;
  assign MEM_B_DATA = mem_db;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET || !CE);

  rearm_fast_a: assert property (state == acq_pkg::S_FOOT && foot_idx == 2'd3 && !seq_last && !abort
                                 && !ovf && {1'b0, rb} + stride + stride <= limit
                                 |-> ##[1:REARM_BOUND] state == acq_pkg::S_ARMED)
    else $error("trigger not re-armed in time");
  stamp_latch_a: assert property (state == acq_pkg::S_ARMED && SAMPLE_VALID && trig && !abort
                                  |=> ts_hold == $past(ts_now))
    else $error("trigger timestamp not latched");
  footer_word_a: assert property (state == acq_pkg::S_FOOT && foot_idx == 2'd0 && !abort
                                  |=> MEM_A_WE && MEM_A_DATA == ts_hold[15:0])
    else $error("footer does not carry the timestamp");
  no_gap_write_a: assert property (state == acq_pkg::S_IDLE || (state != acq_pkg::S_FOOT && !SAMPLE_VALID)
                                   |=> !MEM_A_WE)
    else $error("sample stored outside a record window");
  next_region_a: assert property (state == acq_pkg::S_FOOT && foot_idx == 2'd3 && !abort
                                  |=> rb == $past(rb) + $past(stride[AW-1:0]))
    else $error("record region not advanced by one stride");
  half_split_a: assert property (MEM_B_WE |-> ctrl[acq_pkg::CTRL_DUAL] && MEM_A_WE
                                 && MEM_B_ADDR == MEM_A_ADDR + HALF)
    else $error("channel B outside its half of memory");
  seq_end_a: assert property (state == acq_pkg::S_FOOT && foot_idx == 2'd3 && seq_last && !abort
                              |=> state == acq_pkg::S_IDLE && done
                              && recs_done == ((rec_cnt == 32'h0) ? 32'h1 : rec_cnt))
    else $error("sequence did not end at the record count");
  trig_start_a: assert property (state == acq_pkg::S_ARMED && SAMPLE_VALID && trig && !abort
                                 |=> state == acq_pkg::S_POST || state == acq_pkg::S_FOOT)
    else $error("trigger did not start a record");
  readback_a: assert property (rd_busy && rd_cnt == 4'h0
                               |=> !AVS_WAITREQUEST && AVS_READDATA[15:0] == $past(MEM_RD_DATA))
    else $error("memory readback not returned");
  rearm_hw_a: assert property (state == acq_pkg::S_FOOT && foot_idx == 2'd3 && !seq_last && !abort
                               && {1'b0, rb} + stride + stride <= limit |=> state == acq_pkg::S_ARMED)
    else $error("re-arm depended on software");

  two_records_c: cover property (state == acq_pkg::S_FOOT && foot_idx == 2'd3 && recs_done == 32'h1);
  dual_write_c:  cover property (MEM_B_WE);
  readback_c:    cover property (rd_busy && rd_cnt == 4'h0);
  overflow_c:    cover property (ovf && done);

endmodule
`default_nettype wire

// ---- verification/mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mem_model (
  input  wire logic        clk,
  input  wire logic        a_we,
  input  wire logic [31:0] a_addr,
  input  wire logic [15:0] a_data,
  input  wire logic        b_we,
  input  wire logic [31:0] b_addr,
  input  wire logic [15:0] b_data,
  input  wire logic        rd_en,
  input  wire logic [31:0] rd_addr,
  output logic      [15:0] rd_data
);
  logic [15:0] mem [int unsigned];
  initial rd_data = 16'h0000;
  // Outside the one valid cycle the read bus churns
  always @(posedge clk) begin
    if (a_we) mem[a_addr] = a_data;
    if (b_we) mem[b_addr] = b_data;
    if (rd_en) rd_data <= mem.exists(rd_addr) ? mem[rd_addr] : 16'hdead;
    else rd_data <= ~rd_data;
  end
endmodule
`default_nettype wire

// ---- verification/test_acq_seq.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_acq_seq;
  logic        CORE_CLK = 0, RESET = 1, AVS_READ = 0, AVS_WRITE = 0, SAMPLE_VALID = 0;
  logic        CE = 1, on_b = 0;
  logic [31:0] last_rd = 0, v1 = 0;
  logic [3:0]  AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA, MEM_A_ADDR, MEM_B_ADDR, MEM_RD_ADDR;
  logic [15:0] SAMPLE_A = 0, SAMPLE_B = 0, MEM_A_DATA, MEM_B_DATA, MEM_RD_DATA;
  logic        AVS_WAITREQUEST, MEM_A_WE, MEM_B_WE, MEM_RD_EN;
  int          n_mismatch = 0, checked = 0, ns = 0, nb = 0, maxa = 0;
  int          ts [2];
  logic [31:0] exp_q [$];
  always #5 CORE_CLK = ~CORE_CLK;
  acq_seq uut (.CORE_CLK, .RESET, .CE, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
    .AVS_READDATA, .AVS_WAITREQUEST, .SAMPLE_VALID, .SAMPLE_A, .SAMPLE_B, .MEM_A_WE, .MEM_A_ADDR,
    .MEM_A_DATA, .MEM_B_WE, .MEM_B_ADDR, .MEM_B_DATA, .MEM_RD_EN, .MEM_RD_ADDR, .MEM_RD_DATA);
  mem_model mem (.clk(CORE_CLK), .a_we(MEM_A_WE), .a_addr(MEM_A_ADDR), .a_data(MEM_A_DATA),
    .b_we(MEM_B_WE), .b_addr(MEM_B_ADDR), .b_data(MEM_B_DATA), .rd_en(MEM_RD_EN),
    .rd_addr(MEM_RD_ADDR), .rd_data(MEM_RD_DATA));
  //////////////////////////////////////////////////////////////////////////////
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 0;
    AVS_READ <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(0, a, 0);
  endtask
  task smp(input logic [15:0] v);
    @(posedge CORE_CLK);
    SAMPLE_VALID <= 1;
    SAMPLE_A <= on_b ? 16'($urandom) : v;
    SAMPLE_B <= on_b ? v : 16'($urandom);
    @(posedge CORE_CLK);
    SAMPLE_VALID <= 0;
    ns++;
  endtask
  // Quiet lead-in, crossing sample tv (rising or falling by lo), fixed post tail, then dead time
  task rec(input int r, input logic [15:0] lo, input logic [15:0] tv);
    repeat (6) smp(lo + 16'($urandom % 50));
    ts[r] = ns;
    smp(tv);
    for (int j = 1; j < 4; j++) smp(16'(300 + j));
    repeat (8) smp(lo + 16'($urandom % 50));
  endtask
  // Answers are compared against the oldest expectation
  always @(posedge CORE_CLK) begin
    if (AVS_READ && AVS_WAITREQUEST === 1'b0) begin
      last_rd = AVS_READDATA;
      if (exp_q.size() > 0) cmp(AVS_READDATA, exp_q.pop_front(), "readdata");
    end
    if (MEM_A_WE === 1'b1 && int'(MEM_A_ADDR) > maxa) maxa = int'(MEM_A_ADDR);
    if (MEM_B_WE === 1'b1) nb++;
  end
  initial begin
    #100000;
    n_mismatch++;
    finish_test;
  end
  initial begin
    void'($urandom(32'heb04));
    repeat (2) @(posedge CORE_CLK);
    RESET <= 0;
    rd(acq_pkg::REG_RECS, 1);
    bus(1, acq_pkg::REG_PRE, 4);
    rd(acq_pkg::REG_PRE, 4);
    bus(1, acq_pkg::REG_POST, 4);
    bus(1, acq_pkg::REG_RECS, 2);
    bus(1, acq_pkg::REG_LEVEL, 100);
    bus(1, acq_pkg::REG_CTRL, 32'h21);
    ns = 0;
    rec(0, 16'h0000, 16'h00c8);
    rec(1, 16'h0000, 16'h00c8);
    rd(acq_pkg::REG_STATUS, 32'h4);
    rd(acq_pkg::REG_DONE, 2);
    for (int r = 0; r < 2; r++) begin
      bus(1, acq_pkg::REG_RD_ADDR, r * 12 + 4);
      rd(acq_pkg::REG_RD_DATA, 200);
      for (int j = 1; j < 4; j++) rd(acq_pkg::REG_RD_DATA, 300 + j);
      rd(acq_pkg::REG_RD_DATA, ts[r]);
      rd(acq_pkg::REG_RD_DATA, 0);
      rd(acq_pkg::REG_RD_DATA, 0);
    end
    cmp(maxa, 23, "highest address");
    cmp(nb, 0, "second channel writes");
    bus(1, acq_pkg::REG_CTRL, 32'h04);
    rd(acq_pkg::REG_TS_LO, 0);
    rd(4'hb, 0);
    // Dual channels, falling crossing on B, fixed timestamp clock
    bus(1, acq_pkg::REG_RECS, 1);
    bus(1, acq_pkg::REG_CTRL, 32'hf9);
    on_b = 1;
    rec(0, 16'h00c8, 16'h0032);
    bus(1, acq_pkg::REG_RD_ADDR, 32'h8000_0004);
    rd(acq_pkg::REG_RD_DATA, 32'h32);
    for (int j = 1; j < 4; j++) rd(acq_pkg::REG_RD_DATA, 300 + j);
    cmp(nb, 6 + 4 + acq_pkg::FOOT_WORDS, "second channel writes");
    // Two counter reads taken exactly 100 cycles apart
    bus(0, acq_pkg::REG_TS_LO, 0);
    repeat (97) @(posedge CORE_CLK);
    v1 = last_rd;
    bus(0, acq_pkg::REG_TS_LO, 0);
    @(posedge CORE_CLK);
    cmp(last_rd - v1, 100 / acq_pkg::FIXED_DIV, "fixed clock ticks");
    // Start then abort with no samples
    bus(1, acq_pkg::REG_CTRL, 32'h01);
    rd(acq_pkg::REG_STATUS, 32'h3);
    bus(1, acq_pkg::REG_CTRL, 32'h02);
    rd(acq_pkg::REG_STATUS, 32'h4);
    rd(acq_pkg::REG_DONE, 0);
    @(posedge CORE_CLK);
    cmp(exp_q.size(), 0, "reads left unanswered");
    finish_test;
  end
endmodule
`default_nettype wire
